// ### logic/fsk_word_serial_interface.sv
// Notes on behaviour
// RULE1: Mode pin low device clocks, high external.
// RULE2: Frame start, eight data LSB first, stops.
// RULE3: Bit timing sized for 1200 baud, 1%.
// RULE4: Mode 0 passes demodulated stream to data.
// RULE5: Mode 0 eight mid-cell shift clock pulses.
// RULE6: Mode 0 word ready pulse per word.
// RULE7: Mode 1 loads word, drops word ready.
// RULE8: Mode 1 shifts LSB first on clock rise.
// RULE9: First clock or half bit ends ready.
// RULE10: Extra shift clocks after eight are ignored.
// RULE11: Controller clocks words out after word ready.
// RULE12: Carrier qualified on, released after 8 ms.
// RULE13: No carrier in mode 0: idle outputs.
// RULE14: No carrier in mode 1: no load.
// RULE15: Controller drops demod enable when done.
// RULE16: Interrupt on wake, tone valid, ready.
// RULE17: Controller reads causes, ignores power-up interrupts.
// RULE18: Power-down forces both tone outputs low.
// RULE19: Power-down halts all but wake path.
// RULE20: Timing derived from the master clock rate.
// RULE21: Tone valid is guard-time qualified.
// RULE22: Wake trigger low while stimulus present.
// RULE23: Power-down clears framing state.
module fsk_word_serial_interface
    import fsk_word_pkg::*;
#(
    parameter int unsigned BIT_CYC  = BIT_CYC_DEF,
    parameter int unsigned HALF_CYC = HALF_CYC_DEF,
    parameter int unsigned CD_QUAL  = CD_QUAL_DEF,
    parameter int unsigned CD_HOLD  = CD_HOLD_DEF,
    parameter int unsigned TONE_ON  = TONE_ON_DEF,
    parameter int unsigned TONE_OFF = TONE_OFF_DEF
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Mode and power
    input  wire logic mode_sel,
    input  wire logic power_down,
    input  wire logic demod_enable,
    // Demodulator and detector side
    input  wire logic demod_bit,
    input  wire logic carrier_activity,
    input  wire logic tone_detect,
    // Three-wire interface
    input  wire logic shift_clock_in,
    output logic      shift_clock_out,
    output logic      shift_clock_oe_n,
    output logic      data_out,
    output logic      word_ready_n,
    // Status
    output logic      carrier_present_n,
    output logic      tone_raw,
    output logic      tone_valid,
    // Wake path
    input  wire logic wake_sense_in,
    output logic      wake_trigger_n,
    // Open-drain interrupt
    input  wire logic int_in,
    output logic      int_out,
    output logic      int_oe_n
);
    // Centre sampling restarts at every start edge, so 1% drift
    // costs at most a tenth of a cell by the stop bit
    localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYC - 1);  // [RULE3]
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1); // [RULE20]

    logic [SYNC_W-1:0] sy;
    logic              cd_on;
    logic              tone_q;
    logic              mode_q;
    logic              pd;
    logic              rx;

    assign mode_q = sy[IN_MODE];
    assign pd     = sy[IN_PD];
    // Demodulator off reads as steady mark
    assign rx     = sy[IN_DEMOD] ? sy[IN_DATA] : 1'b1;

    pin_sync #(
        .W   (SYNC_W),
        .RST (SYNC_RST)
    ) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pin   ({wake_sense_in, demod_enable, power_down, mode_sel,
                 shift_clock_in, tone_detect, carrier_activity,
                 demod_bit}),
        .level (sy)
    );

    level_qualify #(
        .W       (CNT_W),
        .ON_CYC  (CD_QUAL),
        .OFF_CYC (CD_HOLD)
    ) u_carrier (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (pd),
        .raw   (sy[IN_ACT]),
        .qual  (cd_on)
    );

    level_qualify #(
        .W       (CNT_W),
        .ON_CYC  (TONE_ON),
        .OFF_CYC (TONE_OFF)
    ) u_tone (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (pd),
        .raw   (sy[IN_TONE]),
        .qual  (tone_q)
    );

    // Receiver framing
    rx_state_e         state;
    rx_state_e         next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic [2:0]        idx;
    logic [2:0]        next_idx;
    logic [WORD_W-1:0] bits;
    logic [WORD_W-1:0] next_bits;
    logic              rx_prev;
    logic              sample;
    logic              data_done;
    logic              stop_ok;

    always_comb begin
        next_state = state;
        next_cnt   = cnt + CNT_W'(1);
        next_idx   = idx;
        next_bits  = bits;
        sample     = 1'b0;
        data_done  = 1'b0;
        stop_ok    = 1'b0;
        case (state)
            RX_IDLE: begin
                next_cnt = '0;
                if (rx_prev && !rx) begin
                    next_state = RX_START;
                end
            end
            RX_START: begin
                if (cnt == HALF_LAST) begin
                    next_cnt   = '0;
                    next_idx   = '0;
                    // Glitch that is gone by mid-cell is no start
                    next_state = rx ? RX_IDLE : RX_DATA; // [RULE2]
                end
            end
            RX_DATA: begin
                if (cnt == BIT_LAST) begin
                    next_cnt  = '0;
                    sample    = 1'b1;
                    next_bits = {rx, bits[WORD_W-1:1]}; // [RULE2]
                    if (idx == IDX_LAST) begin
                        data_done  = 1'b1;
                        next_state = RX_STOP;
                    end else begin
                        next_idx = idx + 3'h1;
                    end
                end
            end
            RX_STOP: begin
                if (cnt == BIT_LAST) begin
                    next_cnt   = '0;
                    // Extra stop bits are just idle mark
                    stop_ok    = rx; // [RULE2]
                    next_state = RX_IDLE;
                end
            end
            default: begin
                next_state = RX_IDLE;
            end
        endcase
        if (pd || !cd_on) begin // [RULE14] [RULE23]
            next_state = RX_IDLE;
            next_cnt   = '0;
            next_idx   = '0;
            next_bits  = '0;
            sample     = 1'b0;
            data_done  = 1'b0;
            stop_ok    = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= RX_IDLE;
            cnt     <= '0;
            idx     <= '0;
            bits    <= '0;
            rx_prev <= 1'b1;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            idx     <= next_idx;
            bits    <= next_bits;
            rx_prev <= rx;
        end
    end

    // Three-wire side
    logic [WORD_W-1:0] sh;
    logic [WORD_W-1:0] next_sh;
    logic [3:0]        left;
    logic [3:0]        next_left;
    logic [CNT_W-1:0]  dr_cnt;
    logic [CNT_W-1:0]  next_dr_cnt;
    logic              sclk_prev;
    logic              sclk_rise;
    logic              next_sclk_out;
    logic              next_data;
    logic              next_dr;

    assign sclk_rise = sy[IN_SCLK] && !sclk_prev;

    always_comb begin
        next_sclk_out = shift_clock_out;
        next_data     = data_out;
        next_dr       = word_ready_n;
        next_dr_cnt   = dr_cnt + CNT_W'(1);
        next_sh       = sh;
        next_left     = left;
        if (!mode_q) begin // [RULE1]
            next_data = cd_on ? rx : 1'b1; // [RULE4] [RULE13]
            next_left = '0;
            if (sample) begin
                next_sclk_out = 1'b1; // [RULE5]
            end else if (cnt == HALF_LAST) begin
                next_sclk_out = 1'b0; // [RULE5]
            end
            if (stop_ok) begin
                next_dr     = 1'b0; // [RULE6]
                next_dr_cnt = '0;
            end else if (!word_ready_n && dr_cnt == HALF_LAST) begin
                next_dr = 1'b1;
            end
            if (!cd_on) begin
                next_sclk_out = 1'b0; // [RULE13]
                next_dr       = 1'b1; // [RULE13]
            end
        end else begin
            next_sclk_out = 1'b0;
            if (data_done) begin
                next_sh     = next_bits; // [RULE7]
                next_left   = BITS_FULL;
                next_dr     = 1'b0; // [RULE7]
                next_dr_cnt = '0;
            end else begin
                if (sclk_rise && left != 4'h0) begin
                    next_data = sh[0]; // [RULE8] [RULE10]
                    next_sh   = {1'b0, sh[WORD_W-1:1]};
                    next_left = left - 4'h1;
                end
                if (!word_ready_n && (sclk_rise || dr_cnt == HALF_LAST)) begin
                    next_dr = 1'b1; // [RULE9]
                end
            end
        end
        if (pd) begin // [RULE19] [RULE23]
            next_sclk_out = 1'b0;
            next_data     = 1'b1;
            next_dr       = 1'b1;
            next_sh       = '0;
            next_left     = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_clock_out  <= 1'b0;
            shift_clock_oe_n <= 1'b1;
            data_out         <= 1'b1;
            word_ready_n     <= 1'b1;
            dr_cnt           <= '0;
            sh               <= '0;
            left             <= '0;
            sclk_prev        <= 1'b0;
        end else begin
            shift_clock_out  <= next_sclk_out;
            shift_clock_oe_n <= mode_q; // [RULE1]
            data_out         <= next_data;
            word_ready_n     <= next_dr;
            dr_cnt           <= next_dr_cnt;
            sh               <= next_sh;
            left             <= next_left;
            sclk_prev        <= sy[IN_SCLK];
        end
    end

    // Status, wake and interrupt
    logic next_int_oe_n;

    // Interrupt follows the registered pins, one cycle behind them
    assign next_int_oe_n = !(!wake_trigger_n || tone_valid || !word_ready_n);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_present_n <= 1'b1;
            tone_raw          <= 1'b0;
            tone_valid        <= 1'b0;
            wake_trigger_n    <= 1'b1;
            int_out           <= 1'b0;
            int_oe_n          <= 1'b1;
        end else begin
            carrier_present_n <= !cd_on;                  // [RULE12]
            tone_raw          <= sy[IN_TONE] && !pd;      // [RULE18]
            tone_valid        <= tone_q && !pd;           // [RULE18] [RULE21]
            wake_trigger_n    <= !sy[IN_WAKE];            // [RULE22]
            int_out           <= 1'b0;
            int_oe_n          <= next_int_oe_n;           // [RULE16]
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_mode0_drives;
        !mode_q |=> !shift_clock_oe_n;
    endproperty
    a_mode0_drives: assert property (p_mode0_drives) // [RULE1]
        else $error("shift clock not driven in mode 0");

    property p_idle_no_carrier;
        (!mode_q && !cd_on) |=> data_out && !shift_clock_out && word_ready_n;
    endproperty
    a_idle_no_carrier: assert property (p_idle_no_carrier) // [RULE13]
        else $error("mode 0 outputs active without carrier");

    property p_sclk_in_data;
        $rose(shift_clock_out) |-> (state == RX_DATA || state == RX_STOP)
            ##1 shift_clock_out [*8];
    endproperty
    a_sclk_in_data: assert property (p_sclk_in_data) // [RULE5]
        else $error("shift clock pulse outside data cells");

    property p_ready_after_stop;
        (!mode_q && $fell(word_ready_n)) |-> $past(state) == RX_STOP;
    endproperty
    a_ready_after_stop: assert property (p_ready_after_stop) // [RULE6]
        else $error("mode 0 word ready not at stop bit");

    property p_load;
        (mode_q && data_done && !pd) |=> !word_ready_n && left == BITS_FULL;
    endproperty
    a_load: assert property (p_load) // [RULE7]
        else $error("word not loaded after eighth bit");

    property p_first_clock;
        (mode_q && !word_ready_n && sclk_rise && !data_done && !pd)
            |=> word_ready_n;
    endproperty
    a_first_clock: assert property (p_first_clock) // [RULE9]
        else $error("word ready not released by first clock");

    property p_half_bit;
        (!word_ready_n && dr_cnt == HALF_LAST && !data_done && !stop_ok)
            |=> word_ready_n;
    endproperty
    a_half_bit: assert property (p_half_bit) // [RULE9]
        else $error("word ready not released after half bit");

    property p_ignore_extra;
        (mode_q && left == 4'h0 && !data_done && !pd) |=> $stable(data_out);
    endproperty
    a_ignore_extra: assert property (p_ignore_extra) // [RULE10]
        else $error("data moved after last bit");

    property p_pd_tone;
        pd |=> !tone_valid && !tone_raw;
    endproperty
    a_pd_tone: assert property (p_pd_tone) // [RULE18]
        else $error("tone outputs high in power-down");

    property p_pd_clear;
        pd |=> state == RX_IDLE && left == 4'h0 && word_ready_n;
    endproperty
    a_pd_clear: assert property (p_pd_clear) // [RULE23]
        else $error("framing state not cleared by power-down");

    property p_int;
        (!wake_trigger_n || tone_valid || !word_ready_n) |=> !int_oe_n;
    endproperty
    a_int: assert property (p_int) // [RULE16]
        else $error("interrupt not asserted");

    property p_wake;
        sy[IN_WAKE] |=> !wake_trigger_n;
    endproperty
    a_wake: assert property (p_wake) // [RULE22]
        else $error("wake trigger not low with stimulus");

    c_mode0_word: cover property (!mode_q && $fell(word_ready_n));
    c_mode1_load: cover property (mode_q && data_done);
    c_mode1_read: cover property (mode_q && !word_ready_n && sclk_rise);
    c_tone_valid: cover property ($rose(tone_valid));

endmodule // fsk_word_serial_interface

// ### shared/fsk_word_pkg.sv
package fsk_word_pkg;

    // Clock and line rate
    localparam int unsigned MCLK_HZ       = 40_000_000;
    localparam int unsigned MASTER_REF_HZ = 3_579_545;
    localparam int unsigned MASTER_TOL_PPM = 1_000;
    localparam int unsigned BAUD_RATE     = 1_200;
    localparam int unsigned HALF_BIT_RATE = 2_400;

    // Times in milliseconds
    localparam int unsigned CD_QUAL_MS = 2;
    localparam int unsigned CD_HOLD_MS = 8;
    localparam int unsigned TONE_GP_MS = 20;
    localparam int unsigned TONE_GA_MS = 16;

    // Derived cycle counts (bit times round down)
    localparam int unsigned BIT_CYC_DEF  = MCLK_HZ / BAUD_RATE;
    localparam int unsigned HALF_CYC_DEF = MCLK_HZ / HALF_BIT_RATE;
    localparam int unsigned CD_QUAL_DEF  = MCLK_HZ / 1_000 * CD_QUAL_MS;
    localparam int unsigned CD_HOLD_DEF  = MCLK_HZ / 1_000 * CD_HOLD_MS;
    localparam int unsigned TONE_ON_DEF  = MCLK_HZ / 1_000 * TONE_GP_MS;
    localparam int unsigned TONE_OFF_DEF = MCLK_HZ / 1_000 * TONE_GA_MS;

    // Widths
    localparam int unsigned CNT_W  = 20;
    localparam int unsigned WORD_W = 8;

    // Synchroniser lanes
    localparam int unsigned SYNC_W   = 8;
    localparam int unsigned IN_DATA  = 0;
    localparam int unsigned IN_ACT   = 1;
    localparam int unsigned IN_TONE  = 2;
    localparam int unsigned IN_SCLK  = 3;
    localparam int unsigned IN_MODE  = 4;
    localparam int unsigned IN_PD    = 5;
    localparam int unsigned IN_DEMOD = 6;
    localparam int unsigned IN_WAKE  = 7;
    // Line idles at mark, everything else low
    localparam logic [SYNC_W-1:0] SYNC_RST = 8'h01;

    localparam logic [2:0] IDX_LAST  = 3'h7;
    localparam logic [3:0] BITS_FULL = 4'h8;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_e;

endpackage

// ### logic/pin_sync.sv
module pin_sync #(
    parameter int unsigned       W   = 1,
    parameter logic [W-1:0]      RST = '0
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Pins in, settled levels out
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_level;

    // A change counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= RST;
            s2    <= RST;
            s3    <= RST;
            level <= RST;
        end else begin
            s1    <= pin;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end
endmodule // pin_sync

// ### logic/level_qualify.sv
module level_qualify #(
    parameter int unsigned W       = 20,
    parameter int unsigned ON_CYC  = 16,
    parameter int unsigned OFF_CYC = 16
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Raw level in, qualified level out
    input  wire logic clear,
    input  wire logic raw,
    output logic      qual
);
    localparam logic [W-1:0] ON_LAST  = W'(ON_CYC - 1);
    localparam logic [W-1:0] OFF_LAST = W'(OFF_CYC - 1);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_qual;

    // Raw must differ without a break for the whole time to flip
    always_comb begin
        next_qual = qual;
        next_cnt  = cnt + W'(1);
        if (raw == qual) begin
            next_cnt = '0;
        end else if (cnt == (qual ? OFF_LAST : ON_LAST)) begin
            next_qual = raw;
            next_cnt  = '0;
        end
        if (clear) begin
            next_qual = 1'b0;
            next_cnt  = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            qual <= 1'b0;
            cnt  <= '0;
        end else begin
            qual <= next_qual;
            cnt  <= next_cnt;
        end
    end
endmodule // level_qualify

// ### verification/fsk_host_model.sv
module fsk_host_model (
    // Clock
    input  wire logic       mclk,
    // Interface from the block
    input  wire logic       mode_sel,
    input  wire logic       slow,
    input  wire logic       sclk_pin,
    input  wire logic       data_in,
    input  wire logic       ready_n,
    // Clock to the block in mode 1
    output logic            sclk_in,
    // Report of each word
    output logic            got,
    output logic [7:0]      word,
    output logic [3:0]      pulses,
    output logic [5:0]      low_len,
    output logic            extra_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] sr;
    int         run;

    initial begin
        sclk_in = 1'b0;
        got = 1'b0;
        sr = 8'h00;
        pulses = 4'h0;
        low_len = 6'h00;
        extra_ok = 1'b0;
        word = 8'h00;
        run = 0;
    end

    // Shift register clocked by the device in mode 0
    always @(posedge sclk_pin) if (!mode_sel) begin
        sr = {data_in, sr[7:1]};
        pulses = pulses + 4'h1;
    end

    always @(posedge mclk) begin
        if (!ready_n) run++;
        else if (run != 0) begin
            low_len = 6'(run);
            run = 0;
        end
    end

    always begin
        @(negedge ready_n);
        if (mode_sel) begin
            // Slow reader lets the ready flag time out first
            repeat (slow ? 30 : 2) @(posedge mclk);
            // Ninth pulse must find nothing left to shift
            for (int i = 0; i < 9; i++) begin
                sclk_in <= 1'b1;
                repeat (8) @(posedge mclk);
                sclk_in <= 1'b0;
                repeat (8) @(posedge mclk);
                extra_ok = (data_in === sr[7]);
                if (i < 8) sr = {data_in, sr[7:1]};
            end
        end else begin
            @(posedge ready_n);
            repeat (2) @(posedge mclk);
        end
        word = sr;
        got <= 1'b1;
        @(posedge mclk);
        got <= 1'b0;
        // Cleared late so the scoreboard still reads this word's count
        pulses <= 4'h0;
    end
endmodule // fsk_host_model

// ### verification/fsk_word_serial_interface_tb.sv
module fsk_word_serial_interface_tb
    import fsk_word_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BC = 40;
    localparam int HC = 20;
    localparam int CQ = 30;
    localparam int CH = 60;
    localparam int TN = 30;

    typedef struct {
        logic [7:0] w;
        logic [5:0] len;
    } note_s;

    logic mclk, rst_n, mode_sel, power_down, demod_enable, demod_bit;
    logic carrier_activity, tone_detect, wake_sense_in, slow, wr_d;
    logic shift_clock_out, shift_clock_oe_n, data_out, word_ready_n;
    logic carrier_present_n, tone_raw, tone_valid, wake_trigger_n;
    logic int_out, int_oe_n, host_sclk, got, extra_ok;
    logic [7:0] word;
    logic [3:0] pulses;
    logic [5:0] low_len, cur_len;
    wire  sclk_pin = shift_clock_oe_n ? host_sclk : shift_clock_out;
    wire  int_pin  = int_oe_n ? 1'b1 : int_out;
    int   bad_count, comparisons, sent, seen;
    note_s exp_q[$];
    note_s nt;

    fsk_word_serial_interface #(.BIT_CYC(BC), .HALF_CYC(HC), .CD_QUAL(CQ),
        .CD_HOLD(CH), .TONE_ON(TN), .TONE_OFF(20)) dut (
        .mclk(mclk), .rst_n(rst_n), .mode_sel(mode_sel),
        .power_down(power_down), .demod_enable(demod_enable),
        .demod_bit(demod_bit), .carrier_activity(carrier_activity),
        .tone_detect(tone_detect), .shift_clock_in(sclk_pin),
        .shift_clock_out(shift_clock_out),
        .shift_clock_oe_n(shift_clock_oe_n), .data_out(data_out),
        .word_ready_n(word_ready_n), .carrier_present_n(carrier_present_n),
        .tone_raw(tone_raw), .tone_valid(tone_valid),
        .wake_sense_in(wake_sense_in), .wake_trigger_n(wake_trigger_n),
        .int_in(int_pin), .int_out(int_out), .int_oe_n(int_oe_n));

    fsk_host_model host (
        .mclk(mclk), .mode_sel(mode_sel), .slow(slow), .sclk_pin(sclk_pin),
        .data_in(data_out), .ready_n(word_ready_n), .sclk_in(host_sclk),
        .got(got), .word(word), .pulses(pulses), .low_len(low_len),
        .extra_ok(extra_ok));

    task automatic check(input logic [7:0] e, input logic [7:0] a);
        comparisons++;
        if (a !== e) begin
            bad_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return carrier_present_n;
            1: return tone_valid;
            2: return wake_trigger_n;
            default: return tone_raw;
        endcase
    endfunction

    task automatic wait_on(input int sel, input logic want, input int lim);
        int n;
        n = 0;
        while (pick(sel) !== want && n < lim) begin
            @(posedge mclk);
            n++;
        end
        check({7'h0, want}, {7'h0, pick(sel)});
    endtask

    task automatic line_bit(input logic v);
        demod_bit <= v;
        repeat (BC) @(posedge mclk);
    endtask

    task automatic send_byte(input logic [7:0] b, input int stops,
                             input bit keep);
        note_s n;
        n.w = b;
        n.len = cur_len;
        if (keep) begin
            exp_q.push_back(n);
            sent++;
        end
        line_bit(1'b0);
        for (int i = 0; i < 8; i++) line_bit(b[i]);
        repeat (stops) line_bit(1'b1);
    endtask

    // Scoreboard: oldest note against each reported word
    always @(posedge mclk) begin
        wr_d <= word_ready_n;
        if (word_ready_n === 1'b0 && wr_d === 1'b0)
            check(8'h00, {7'h0, int_oe_n});
        if (got === 1'b1) begin
            seen++;
            nt = exp_q.size() != 0 ? exp_q.pop_front() : '{8'h00, 6'h00};
            check(nt.w, word);
            if (nt.len != 6'h00) check({2'h0, nt.len}, {2'h0, low_len});
            if (!mode_sel) check(8'h08, {4'h0, pulses});
            if (mode_sel) check(8'h01, {7'h0, extra_ok});
        end
    end

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end

    initial begin
        {rst_n, mode_sel, power_down, carrier_activity} = 4'h0;
        {tone_detect, wake_sense_in, slow} = 3'h0;
        {demod_enable, demod_bit} = 2'h3;
        // Ready stays low for half a bit time
        cur_len = 6'(HC);
        void'($urandom(92));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (10) @(posedge mclk);
        check(8'h00, {7'h0, shift_clock_oe_n});
        carrier_activity <= 1'b1;
        repeat (CQ - 5) @(posedge mclk);
        check(8'h01, {7'h0, carrier_present_n});
        wait_on(0, 1'b0, 20);
        send_byte(8'h00, 10, 1'b1);
        send_byte(8'hff, 1, 1'b1);
        repeat (4) send_byte(8'($urandom), 1 + $urandom_range(2), 1'b1);
        // Dropout shorter than the hold keeps the carrier
        carrier_activity <= 1'b0;
        repeat (CH - 20) @(posedge mclk);
        carrier_activity <= 1'b1;
        repeat (10) @(posedge mclk);
        check(8'h00, {7'h0, carrier_present_n});
        carrier_activity <= 1'b0;
        wait_on(0, 1'b1, CH + 20);
        fork
            send_byte(8'h00, 2, 1'b0);
            begin
                repeat (3 * BC) @(posedge mclk);
                check(8'h01, {7'h0, data_out});
            end
        join
        demod_enable <= 1'b0;
        carrier_activity <= 1'b1;
        wait_on(0, 1'b0, CQ + 20);
        // Demodulator off: no word may come out
        send_byte(8'h00, 1, 1'b0);
        demod_enable <= 1'b1;
        mode_sel <= 1'b1;
        repeat (10) @(posedge mclk);
        check(8'h01, {7'h0, shift_clock_oe_n});
        cur_len = 6'h00;
        repeat (3) send_byte(8'($urandom), 1, 1'b1);
        slow <= 1'b1;
        cur_len = 6'(HC);
        send_byte(8'ha5, 2, 1'b1);
        send_byte(8'($urandom), 2, 1'b1);
        // Mode 1 without carrier must not load a word
        carrier_activity <= 1'b0;
        wait_on(0, 1'b1, CH + 20);
        send_byte(8'h3c, 1, 1'b0);
        carrier_activity <= 1'b1;
        wait_on(0, 1'b0, CQ + 20);
        repeat (300) @(posedge mclk);
        check(8'(sent), 8'(seen));
        tone_detect <= 1'b1;
        wait_on(3, 1'b1, 10);
        repeat (TN - 10) @(posedge mclk);
        check(8'h00, {7'h0, tone_valid});
        wait_on(1, 1'b1, 20);
        repeat (3) @(posedge mclk);
        check(8'h00, {7'h0, int_oe_n});
        check(8'h01, {7'h0, tone_valid});
        power_down <= 1'b1;
        wait_on(1, 1'b0, 10);
        wait_on(3, 1'b0, 10);
        wake_sense_in <= 1'b1;
        wait_on(2, 1'b0, 10);
        wake_sense_in <= 1'b0;
        wait_on(2, 1'b1, 10);
        give_verdict();
    end
endmodule // fsk_word_serial_interface_tb
